// File: pkg/gpi_pkg.sv
// package: constants, field layout, codes and carrier types of the pulse port
//------------------------------------------------------------------------------
// Overview of operation
// - opto pair decodes command pulse streams up to 500 kHz per line
// - opto input state and counts are published every 2 us
// - differential port as input decodes streams up to 3 MHz per line
// - two lines carry pulse/dir, cw/ccw or A/B; differential adds zero
// - format 0 with source 1 selects differential port as quadrature source
// - format 0 with source 2 selects opto pair as quadrature source
// - third format 0 with emulation mode 11 selects serial absolute input
// - differential port is either command input or emulated output
// - A, B and index are made from primary absolute position
// - emulated A and B stay in quadrature, 90 +/- 20 degrees
// - emulated output never exceeds 3 MHz per channel
// - emulated lines per turn follow the emulation resolution setting
// - one zero pulse per turn at the programmed zero offset
// - pulse/direction counts scaled by adjustable pulses-per-motion factor
// - slave drives follow master emulated output as command input
//------------------------------------------------------------------------------
package gpi_pkg;

  //----------------------------------------------------------------------------
  // timing
  //----------------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 250_000_000;
  localparam int unsigned CLK_PERIOD_PS    = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int unsigned OPTO_UPDATE_NS   = 2000;
  localparam int unsigned OPTO_UPDATE_CYC  =
    (OPTO_UPDATE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned EMU_MAX_HZ       = 3_000_000;
  localparam int unsigned EMU_EDGES_PER_CH = 4;
  localparam int unsigned EMU_EDGE_MIN_CYC =
    (CLK_HZ + EMU_EDGES_PER_CH * EMU_MAX_HZ - 1)
    / (EMU_EDGES_PER_CH * EMU_MAX_HZ);

  //----------------------------------------------------------------------------
  // register map (byte addresses)
  //----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG     = 8'h00;
  localparam logic [7:0] ADDR_EMU_RES = 8'h04;
  localparam logic [7:0] ADDR_EMU_ZOF = 8'h08;
  localparam logic [7:0] ADDR_GEAR    = 8'h0C;
  localparam logic [7:0] ADDR_CMD_POS = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;

  localparam int unsigned CFG_FMT_LSB = 0;
  localparam int unsigned CFG_SRC_LSB = 4;
  localparam int unsigned CFG_FB3_LSB = 8;
  localparam int unsigned CFG_EMU_LSB = 12;

  localparam int unsigned ST_DIFF_IN  = 0;
  localparam int unsigned ST_EMU_OUT  = 1;
  localparam int unsigned ST_ABS_SER  = 2;
  localparam int unsigned ST_ZERO     = 3;
  localparam int unsigned ST_OPTO_LSB = 4;

  localparam logic [15:0] EMU_RES_RST = 16'h0400;
  localparam logic [15:0] EMU_ZOF_RST = 16'h0000;
  localparam logic [15:0] GEAR_RST    = 16'h0001;
  localparam logic [1:0]  FB3_RST     = 2'h1;

  //----------------------------------------------------------------------------
  // codes
  //----------------------------------------------------------------------------
  localparam logic [1:0] FMT_QUAD      = 2'h0;
  localparam logic [1:0] FMT_PULSE_DIR = 2'h1;
  localparam logic [1:0] FMT_CW_CCW    = 2'h2;
  localparam logic [1:0] SRC_DIFF      = 2'h1;
  localparam logic [1:0] SRC_OPTO      = 2'h2;
  localparam logic [1:0] FB3_DIFF      = 2'h0;
  localparam logic [3:0] EMU_MODE_IN   = 4'h0;
  localparam logic [3:0] EMU_MODE_OUT  = 4'h1;
  localparam logic [3:0] EMU_MODE_ABS  = 4'hB;

  //----------------------------------------------------------------------------
  // carriers
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] secondary_feedback_format;
    logic [1:0] secondary_feedback_source;
    logic [1:0] third_feedback_format;
    logic [3:0] emulation_port_mode;
  } gpi_cfg_t;

  typedef struct packed {
    logic up;
    logic dn;
    logic zero;
  } gpi_cnt_t;

endpackage

// File: design/gpi_decode.sv
// module: two-line pulse stream decoder for the command inputs
`timescale 1ns/100ps
module gpi_decode
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             en,
  input  wire logic [1:0]       fmt,
  input  wire logic             line1,
  input  wire logic             line2,
  input  wire logic             line_z,
  output gpi_pkg::gpi_cnt_t     cnt
);

  typedef struct packed {
    logic              p1;
    logic              p2;
    logic              pz;
    gpi_pkg::gpi_cnt_t cnt;
  } gpi_dec_st_t;

  gpi_dec_st_t st;
  gpi_dec_st_t next_st;

  always_comb
  begin
    next_st     = st;
    next_st.cnt = '0;
    // history follows even while disabled: no false edge on enable
    next_st.p1  = line1;
    next_st.p2  = line2;
    next_st.pz  = line_z;
    if (en)
    begin
      case (fmt)
        gpi_pkg::FMT_QUAD:
        begin
          // both lines changing at once is illegal and is dropped
          if ((line1 ^ st.p1) ^ (line2 ^ st.p2))
          begin
            next_st.cnt.up = line1 ^ st.p2;
            next_st.cnt.dn = ~(line1 ^ st.p2);
          end
          next_st.cnt.zero = line_z & ~st.pz;
        end
        gpi_pkg::FMT_PULSE_DIR:
        begin
          if (line1 & ~st.p1)
          begin
            next_st.cnt.up = line2;
            next_st.cnt.dn = ~line2;
          end
        end
        gpi_pkg::FMT_CW_CCW:
        begin
          next_st.cnt.up = line1 & ~st.p1;
          next_st.cnt.dn = line2 & ~st.p2;
        end
        default:
        begin
          next_st.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign cnt = st.cnt;

endmodule

// File: design/gpi_emulate.sv
// module: emulated quadrature encoder output built from absolute position
`timescale 1ns/100ps
module gpi_emulate
#(
  parameter int unsigned POS_W = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             en,
  input  wire logic [POS_W-1:0] pos,
  input  wire logic [15:0]      res,
  input  wire logic [15:0]      zoff,
  output logic                  qa,
  output logic                  qb,
  output logic                  qz
);

  localparam int unsigned GAP_W = $clog2(gpi_pkg::EMU_EDGE_MIN_CYC + 1);
  localparam logic [GAP_W-1:0] GAP_LOAD =
    GAP_W'(gpi_pkg::EMU_EDGE_MIN_CYC - 1);

  typedef struct packed {
    logic [17:0]      cnt;
    logic [GAP_W-1:0] gap;
    logic             qa;
    logic             qb;
    logic             qz;
  } gpi_emu_st_t;

  gpi_emu_st_t      st;
  gpi_emu_st_t      next_st;
  logic [17:0]      total;
  logic [17:0]      target;
  logic [17:0]      diff;
  logic [17:0]      cnt_n;
  logic [POS_W+17:0] prod;

  always_comb
  begin
    total   = {res, 2'b00};
    prod    = (POS_W+18)'(pos) * (POS_W+18)'(total);
    target  = prod[POS_W+17:POS_W];
    diff    = target - st.cnt;
    cnt_n   = st.cnt;
    next_st = st;
    if (st.gap != '0)
      next_st.gap = st.gap - GAP_W'(1);
    if (en && (res != 16'h0000) && (st.gap == '0) && (target != st.cnt))
    begin
      // shortest way round the turn, one edge per step
      if (diff < {1'b0, total[17:1]} || st.cnt > target && (st.cnt - target)
          > {1'b0, total[17:1]})
        cnt_n = (st.cnt == total - 18'h0_0001) ? '0 : st.cnt + 18'h0_0001;
      else
        cnt_n = (st.cnt == '0) ? total - 18'h0_0001 : st.cnt - 18'h0_0001;
      next_st.gap = GAP_LOAD;
    end
    next_st.cnt = cnt_n;
    next_st.qa  = en & (cnt_n[1] ^ cnt_n[0]);
    next_st.qb  = en & cnt_n[1];
    next_st.qz  = en & (cnt_n[17:2] == zoff) & (cnt_n[1:0] == 2'b00);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign qa = st.qa;
  assign qb = st.qb;
  assign qz = st.qz;

endmodule

// File: design/gpi_top.sv
// module: gearing pulse port top with APB register slave
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module gpi_top
#(
  parameter int unsigned POS_W = 16
)
(
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             CE,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic             DIFF_A_I,
  input  wire logic             DIFF_B_I,
  input  wire logic             DIFF_Z_I,
  output logic                  DIFF_A_O,
  output logic                  DIFF_B_O,
  output logic                  DIFF_Z_O,
  output logic                  DIFF_OE,
  input  wire logic             OPTO_IN1,
  input  wire logic             OPTO_IN2,
  input  wire logic [POS_W-1:0] PRIM_POS,
  output logic      [31:0]      CMD_POS,
  output logic                  ABS_SERIAL_SEL
);

  localparam int unsigned TICK_W = $clog2(gpi_pkg::OPTO_UPDATE_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST =
    TICK_W'(gpi_pkg::OPTO_UPDATE_CYC - 1);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        dsync1;
    logic [2:0]        dsync2;
    logic [1:0]        osync1;
    logic [1:0]        osync2;
    gpi_pkg::gpi_cfg_t cfg;
    logic [15:0]       emu_res;
    logic [15:0]       emu_zof;
    logic [15:0]       gear;
    logic [31:0]       cmd_pos;
    logic [15:0]       opto_pend;
    logic [TICK_W-1:0] tick;
    logic [1:0]        opto_state;
    logic              diff_oe;
    logic              abs_sel;
    logic              zero_seen;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } gpi_top_st_t;

  gpi_top_st_t       st;
  gpi_top_st_t       next_st;
  gpi_pkg::gpi_cnt_t diff_cnt;
  gpi_pkg::gpi_cnt_t opto_cnt;
  logic              diff_in_act;
  logic              emu_out_act;
  logic              abs_sel;
  logic              opto_act;
  logic              diff_dec_en;
  logic              setup;
  logic              wr_take;
  logic              zero_clr;
  logic              mapped;
  logic [31:0]       rd_val;
  logic [31:0]       gear_ext;
  logic [31:0]       pend_ext;
  logic [31:0]       diff_step;
  logic [15:0]       pend_step;
  logic [31:0]       pos_acc;

  //----------------------------------------------------------------------------
  // port direction and source selection
  //----------------------------------------------------------------------------
  always_comb
  begin
    // the port is one direction at a time; only input mode 0 listens
    emu_out_act = st.cfg.emulation_port_mode == gpi_pkg::EMU_MODE_OUT;
    abs_sel     = (st.cfg.third_feedback_format == gpi_pkg::FB3_DIFF)
                  && (st.cfg.emulation_port_mode == gpi_pkg::EMU_MODE_ABS);
    diff_in_act = st.cfg.emulation_port_mode == gpi_pkg::EMU_MODE_IN;
    // incremental decode only; serial absolute traffic is handled elsewhere
    diff_dec_en = diff_in_act
                  && (st.cfg.secondary_feedback_source == gpi_pkg::SRC_DIFF);
    opto_act    = st.cfg.secondary_feedback_source
                  == gpi_pkg::SRC_OPTO;
  end

  //----------------------------------------------------------------------------
  // decoders
  //----------------------------------------------------------------------------
  // both run at full clock rate: 4 ns sampling easily resolves 3 MHz
  gpi_decode u_diff_dec
  (
    .clk    (CLK),
    .rst_n  (RST_N),
    .ce     (CE),
    .en     (diff_dec_en),
    .fmt    (st.cfg.secondary_feedback_format),
    .line1  (st.dsync2[0]),
    .line2  (st.dsync2[1]),
    .line_z (st.dsync2[2]),
    .cnt    (diff_cnt)
  );

  gpi_decode u_opto_dec
  (
    .clk    (CLK),
    .rst_n  (RST_N),
    .ce     (CE),
    .en     (opto_act),
    .fmt    (st.cfg.secondary_feedback_format),
    .line1  (st.osync2[0]),
    .line2  (st.osync2[1]),
    .line_z (1'b0),
    .cnt    (opto_cnt)
  );

  //----------------------------------------------------------------------------
  // emulated encoder
  //----------------------------------------------------------------------------
  gpi_emulate
  #(
    .POS_W (POS_W)
  )
  u_emu
  (
    .clk   (CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .en    (emu_out_act),
    .pos   (PRIM_POS),
    .res   (st.emu_res),
    .zoff  (st.emu_zof),
    .qa    (DIFF_A_O),
    .qb    (DIFF_B_O),
    .qz    (DIFF_Z_O)
  );

  //----------------------------------------------------------------------------
  // register read mux
  //----------------------------------------------------------------------------
  always_comb
  begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR)
      gpi_pkg::ADDR_CFG:
      begin
        rd_val[gpi_pkg::CFG_FMT_LSB +: 2] = st.cfg.secondary_feedback_format;
        rd_val[gpi_pkg::CFG_SRC_LSB +: 2] = st.cfg.secondary_feedback_source;
        rd_val[gpi_pkg::CFG_FB3_LSB +: 2] = st.cfg.third_feedback_format;
        rd_val[gpi_pkg::CFG_EMU_LSB +: 4] = st.cfg.emulation_port_mode;
      end
      gpi_pkg::ADDR_EMU_RES:
        rd_val[15:0] = st.emu_res;
      gpi_pkg::ADDR_EMU_ZOF:
        rd_val[15:0] = st.emu_zof;
      gpi_pkg::ADDR_GEAR:
        rd_val[15:0] = st.gear;
      gpi_pkg::ADDR_CMD_POS:
        rd_val = st.cmd_pos;
      gpi_pkg::ADDR_STATUS:
      begin
        rd_val[gpi_pkg::ST_DIFF_IN]       = diff_in_act;
        rd_val[gpi_pkg::ST_EMU_OUT]       = emu_out_act;
        rd_val[gpi_pkg::ST_ABS_SER]       = abs_sel;
        rd_val[gpi_pkg::ST_ZERO]          = st.zero_seen;
        rd_val[gpi_pkg::ST_OPTO_LSB +: 2] = st.opto_state;
      end
      default:
        mapped = 1'b0;
    endcase
  end

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb
  begin
    next_st   = st;
    setup     = PSEL & ~PENABLE;
    wr_take   = PSEL & PENABLE & st.pready & PWRITE;
    zero_clr  = setup & ~PWRITE & (PADDR == gpi_pkg::ADDR_STATUS);
    gear_ext  = {16'h0000, st.gear};
    diff_step = 32'h0000_0000;
    pend_step = 16'h0000;
    pend_ext  = {{16{st.opto_pend[15]}}, st.opto_pend};

    // two-stage synchronisers; only the second stage feeds logic
    next_st.dsync1 = {DIFF_Z_I, DIFF_B_I, DIFF_A_I};
    next_st.dsync2 = st.dsync1;
    next_st.osync1 = {OPTO_IN2, OPTO_IN1};
    next_st.osync2 = st.osync1;

    // differential counts land at once, scaled per pulse
    if (diff_cnt.up)
      diff_step = gear_ext;
    else if (diff_cnt.dn)
      diff_step = 32'h0000_0000 - gear_ext;

    // opto counts gather here and are published on the update tick
    if (opto_cnt.up)
      pend_step = 16'h0001;
    else if (opto_cnt.dn)
      pend_step = 16'hFFFF;

    pos_acc = st.cmd_pos + diff_step;
    if (st.tick == TICK_LAST)
    begin
      next_st.tick       = '0;
      next_st.opto_state = st.osync2;
      pos_acc            = pos_acc + pend_ext * gear_ext;
      // a count arriving in the tick cycle starts the next batch
      next_st.opto_pend  = pend_step;
    end
    else
    begin
      next_st.tick      = st.tick + TICK_W'(1);
      next_st.opto_pend = st.opto_pend + pend_step;
    end
    next_st.cmd_pos = pos_acc;

    next_st.diff_oe = emu_out_act;
    next_st.abs_sel = abs_sel;

    // mark seen since last status read; set beats clear
    if (diff_cnt.zero)
      next_st.zero_seen = 1'b1;
    else if (zero_clr)
      next_st.zero_seen = 1'b0;

    // APB: one wait-free access cycle after setup
    next_st.pready  = setup;
    next_st.pslverr = setup & ~mapped;
    if (setup)
      next_st.prdata = PWRITE ? 32'h0000_0000 : rd_val;
    if (wr_take)
    begin
      case (PADDR)
        gpi_pkg::ADDR_CFG:
        begin
          next_st.cfg.secondary_feedback_format =
            PWDATA[gpi_pkg::CFG_FMT_LSB +: 2];
          next_st.cfg.secondary_feedback_source =
            PWDATA[gpi_pkg::CFG_SRC_LSB +: 2];
          next_st.cfg.third_feedback_format =
            PWDATA[gpi_pkg::CFG_FB3_LSB +: 2];
          next_st.cfg.emulation_port_mode =
            PWDATA[gpi_pkg::CFG_EMU_LSB +: 4];
        end
        gpi_pkg::ADDR_EMU_RES:
          next_st.emu_res = PWDATA[15:0];
        gpi_pkg::ADDR_EMU_ZOF:
          next_st.emu_zof = PWDATA[15:0];
        gpi_pkg::ADDR_GEAR:
          next_st.gear = PWDATA[15:0];
        // a preset overrides any differential count or opto batch published in the same cycle
        gpi_pkg::ADDR_CMD_POS:
          next_st.cmd_pos = PWDATA;
        default:
          next_st.cfg = st.cfg;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st                           <= '0;
      st.cfg.third_feedback_format <= gpi_pkg::FB3_RST;
      st.emu_res                   <= gpi_pkg::EMU_RES_RST;
      st.emu_zof                   <= gpi_pkg::EMU_ZOF_RST;
      st.gear                      <= gpi_pkg::GEAR_RST;
    end
    else if (CE)
      st <= next_st;
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign PRDATA         = st.prdata;
  assign PREADY         = st.pready;
  assign PSLVERR        = st.pslverr;
  assign DIFF_OE        = st.diff_oe;
  assign CMD_POS        = st.cmd_pos;
  assign ABS_SERIAL_SEL = st.abs_sel;

endmodule

// File: bench/gpi_top_assertions.sv
// checker: port-level timing relations of the pulse port top
`timescale 1ns/100ps
module gpi_top_assertions
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        DIFF_A_O,
  input wire logic        DIFF_B_O,
  input wire logic        DIFF_Z_O,
  input wire logic        DIFF_OE,
  input wire logic        ABS_SERIAL_SEL
);
  logic [7:0] gap_cnt;
  logic       a_q;
  logic       b_q;
  logic       emu_edge;
  logic       unmapped;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  assign emu_edge = (DIFF_A_O != a_q) || (DIFF_B_O != b_q);
  assign unmapped = (PADDR > 8'h14) || (PADDR[1:0] != 2'h0);

  // saturates so a long idle never wraps into a false short gap
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      gap_cnt <= 8'hFF;
      a_q     <= 1'b0;
      b_q     <= 1'b0;
    end
    else
    begin
      a_q     <= DIFF_A_O;
      b_q     <= DIFF_B_O;
      if (emu_edge)
        gap_cnt <= 8'h00;
      else if (gap_cnt != 8'hFF)
        gap_cnt <= gap_cnt + 8'h01;
    end
  end

  // ----------
  // bus answer
  // ----------
  sequence s_setup;
    PSEL && !PENABLE && CE;
  endsequence
  sequence s_done;
    PSEL && PENABLE && PREADY;
  endsequence

  a_setup_ready: assert property (s_setup |=> PREADY)
    else $error("no ready one cycle after setup");
  a_ready_pulse: assert property (PREADY && CE |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
    else $error("error without ready or with nonzero data");
  a_slverr_map: assert property (s_done |-> PSLVERR == unmapped)
    else $error("error flag does not match address map");

  // ----------
  // emulated encoder
  // ----------
  a_port_role: assert property (!(DIFF_OE && ABS_SERIAL_SEL))
    else $error("port output and serial input both selected");
  a_emu_idle: assert property (!DIFF_OE && !$past(DIFF_OE) |->
    !DIFF_A_O && !DIFF_B_O && !DIFF_Z_O)
    else $error("emulated lines active while port is input");
  a_one_edge: assert property (DIFF_OE && $past(DIFF_OE) &&
    $changed(DIFF_A_O) |-> $stable(DIFF_B_O))
    else $error("both channels changed in one cycle");
  a_edge_gap: assert property (emu_edge && DIFF_OE && $past(DIFF_OE) |->
    gap_cnt >= 8'h14)
    else $error("emulated edges closer than 21 cycles");
  a_index_quad: assert property (DIFF_Z_O |-> !DIFF_A_O && !DIFF_B_O)
    else $error("index outside the A low B low quarter");
endmodule

bind gpi_top gpi_top_assertions u_chk
(
  .CLK (CLK), .RST_N (RST_N), .CE (CE), .PSEL (PSEL), .PENABLE (PENABLE),
  .PADDR (PADDR), .PRDATA (PRDATA), .PREADY (PREADY), .PSLVERR (PSLVERR),
  .DIFF_A_O (DIFF_A_O), .DIFF_B_O (DIFF_B_O), .DIFF_Z_O (DIFF_Z_O),
  .DIFF_OE (DIFF_OE), .ABS_SERIAL_SEL (ABS_SERIAL_SEL)
);

// File: bench/gpi_cmd_source.sv
// partner model: stepper controller or external encoder on two lines
`timescale 1ns/100ps
module gpi_cmd_source
(
  input  wire logic clk,
  output logic      line1,
  output logic      line2
);
  logic [1:0] ph = 2'h0;

  initial
  begin
    line1 = 1'b0;
    line2 = 1'b0;
  end

  // push-pull lines: they keep their level between bursts
  task automatic send(input logic [1:0] fmt, input int n, input logic up,
                      input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (fmt == gpi_pkg::FMT_QUAD)
      begin
        ph = up ? ph + 2'h1 : ph - 2'h1;
        line1 <= ph[1] ^ ph[0];
        line2 <= ph[1];
        repeat (gap) @(posedge clk);
      end
      else
      begin
        if (fmt == gpi_pkg::FMT_PULSE_DIR)
          line2 <= up;
        repeat (gap) @(posedge clk);
        if (fmt == gpi_pkg::FMT_CW_CCW && !up)
          line2 <= 1'b1;
        else
          line1 <= 1'b1;
        repeat (gap) @(posedge clk);
        line1 <= 1'b0;
        if (fmt == gpi_pkg::FMT_CW_CCW)
          line2 <= 1'b0;
      end
    end
  endtask
endmodule

// File: bench/tb.sv
// testbench: registers, command decoding and encoder emulation
`timescale 1ns/100ps
module tb;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        a_o;
  logic        b_o;
  logic        z_o;
  logic        oe;
  logic [15:0] prim_pos;
  logic [31:0] cmd_pos;
  logic        abs_sel;
  logic        d1;
  logic        d2;
  logic        o1;
  logic        o2;
  logic        ce;
  logic        z_i = 1'b0;
  logic        a_q = 1'b0;
  logic        b_q = 1'b0;
  int          n_fail = 0;
  int          compares = 0;
  int          edges = 0;
  int          cyc = 0;

  gpi_top uut
  (
    .CLK (clk), .RST_N (rst_n), .CE (ce), .PSEL (psel),
    .PENABLE (penable), .PWRITE (pwrite), .PADDR (paddr), .PWDATA (pwdata),
    .PRDATA (prdata), .PREADY (pready), .PSLVERR (pslverr),
    .DIFF_A_I (d1), .DIFF_B_I (d2), .DIFF_Z_I (z_i), .DIFF_A_O (a_o),
    .DIFF_B_O (b_o), .DIFF_Z_O (z_o), .DIFF_OE (oe), .OPTO_IN1 (o1),
    .OPTO_IN2 (o2), .PRIM_POS (prim_pos), .CMD_POS (cmd_pos),
    .ABS_SERIAL_SEL (abs_sel)
  );
  gpi_cmd_source src_d (.clk (clk), .line1 (d1), .line2 (d2));
  gpi_cmd_source src_o (.clk (clk), .line1 (o1), .line2 (o2));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------
  // monitors and helpers
  // ----------
  always @(posedge clk)
  begin
    a_q <= a_o;
    b_q <= b_o;
    if (a_o !== a_q || b_o !== b_q)
      edges++;
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
    chk({31'h0, e}, 32'h0000_0000);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    chk(rd, exp);
  endtask

  // preset wins over counts, so stale line levels cannot leak in
  task automatic run_cmd(input logic [31:0] cfg, input logic [31:0] gear,
    input logic [1:0] fmt, input int nu, input int nd, input int gap,
    input logic opto, input logic [31:0] exp);
    wr(gpi_pkg::ADDR_CFG, cfg);
    wr(gpi_pkg::ADDR_GEAR, gear);
    repeat (8) @(posedge clk);
    wr(gpi_pkg::ADDR_CMD_POS, 32'h0000_0000);
    if (opto)
    begin
      src_o.send(fmt, nu, 1'b1, gap);
      src_o.send(fmt, nd, 1'b0, gap);
    end
    else
    begin
      src_d.send(fmt, nu, 1'b1, gap);
      src_d.send(fmt, nd, 1'b0, gap);
    end
    repeat (520) @(posedge clk);
    rdc(gpi_pkg::ADDR_CMD_POS, exp);
    chk(cmd_pos, exp);
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_reset_values();
    logic [31:0] rd;
    logic        e;
    rdc(gpi_pkg::ADDR_CFG, 32'h0000_0100);
    rdc(gpi_pkg::ADDR_EMU_RES, 32'h0000_0400);
    rdc(gpi_pkg::ADDR_EMU_ZOF, 32'h0000_0000);
    rdc(gpi_pkg::ADDR_GEAR, 32'h0000_0001);
    apb(1'b0, 8'h18, 32'h0000_0000, rd, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask

  task automatic t_diff_cmd();
    run_cmd(32'h0000_0011, 3, gpi_pkg::FMT_PULSE_DIR, 5, 1, 42,
      1'b0, 32'h0000_000C);
    run_cmd(32'h0000_0012, 2, gpi_pkg::FMT_CW_CCW, 3, 1, 42,
      1'b0, 32'h0000_0004);
    run_cmd(32'h0000_0010, 1, gpi_pkg::FMT_QUAD, 7, 2, 20,
      1'b0, 32'h0000_0005);
    z_i <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(gpi_pkg::ADDR_STATUS, 32'h0000_0009);
    rdc(gpi_pkg::ADDR_STATUS, 32'h0000_0001);
  endtask

  task automatic t_opto_cmd();
    run_cmd(32'h0000_0010, 1, gpi_pkg::FMT_QUAD, 4, 0, 124,
      1'b1, 32'h0000_0000);
    run_cmd(32'h0000_0020, 1, gpi_pkg::FMT_QUAD, 2, 6, 124,
      1'b1, 32'hFFFF_FFFC);
  endtask

  task automatic t_emulate();
    wr(gpi_pkg::ADDR_EMU_RES, 32'h0000_0010);
    wr(gpi_pkg::ADDR_EMU_ZOF, 32'h0000_0001);
    wr(gpi_pkg::ADDR_CFG, 32'h0000_1000);
    repeat (4) @(posedge clk);
    chk({31'h0, oe}, 32'h0000_0001);
    edges = 0;
    prim_pos <= 16'h1000;
    repeat (300) @(posedge clk);
    chk(edges, 32'h0000_0004);
    chk({29'h0, z_o, b_o, a_o}, 32'h0000_0004);
    ce       <= 1'b0;
    prim_pos <= 16'hF000;
    repeat (100) @(posedge clk);
    chk(edges, 32'h0000_0004);
    ce       <= 1'b1;
    repeat (300) @(posedge clk);
    chk(edges, 32'h0000_000C);
    chk({29'h0, z_o, b_o, a_o}, 32'h0000_0000);
    wr(gpi_pkg::ADDR_CFG, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk({28'h0, oe, z_o, b_o, a_o}, 32'h0000_0000);
  endtask

  task automatic t_abs_select();
    wr(gpi_pkg::ADDR_CFG, 32'h0000_B000);
    repeat (4) @(posedge clk);
    chk({30'h0, abs_sel, oe}, 32'h0000_0002);
    rdc(gpi_pkg::ADDR_STATUS, 32'h0000_0004);
    wr(gpi_pkg::ADDR_CFG, 32'h0000_B100);
    rdc(gpi_pkg::ADDR_CFG, 32'h0000_B100);
    chk({30'h0, abs_sel, oe}, 32'h0000_0000);
  endtask

  initial
  begin
    rst_n    = 1'b0;
    ce       = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    prim_pos = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_diff_cmd();
    t_opto_cmd();
    t_emulate();
    t_abs_select();
    test_done();
  end
endmodule
